// ### cta_consts.svh
/*
  Encodings, field positions and reset values for the cache test access block.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef CTA_CONSTS_SVH
`define CTA_CONSTS_SVH

// Coprocessor opcode_1 values
`define CTA_OPC1_MAINT    3'h0
`define CTA_OPC1_CACHE    3'h2
`define CTA_OPC1_TDATA    3'h3
`define CTA_OPC1_TSTATE   3'h7

// Coprocessor primary register numbers
`define CTA_CRN_INV       4'h7
`define CTA_CRN_VIC       4'h9
`define CTA_CRN_TEST      4'hF

// Coprocessor CRm values
`define CTA_CRM_INV       4'h7
`define CTA_CRM_VIC_BASE  4'h0
`define CTA_CRM_VIC       4'h1
`define CTA_CRM_TAG       4'h7
`define CTA_CRM_DATA      4'hB
`define CTA_CRM_TDATA     4'h3
`define CTA_CRM_TSTATE    4'hF

// Coprocessor opcode_2 values
`define CTA_OPC2_INV      3'h0
`define CTA_OPC2_TAG_RD   3'h2
`define CTA_OPC2_TAG_WR   3'h6
`define CTA_OPC2_DAT_RD   3'h2
`define CTA_OPC2_DAT_WR   3'h6
`define CTA_OPC2_MATCH    3'h5
`define CTA_OPC2_TDATA    3'h0
`define CTA_OPC2_VCAP     3'h1
`define CTA_OPC2_TSTATE   3'h7

// Field positions in the source value
`define CTA_SEG_LSB       5
`define CTA_WORD_LSB      2
`define CTA_TAG_LSB       7
`define CTA_VALID_BIT     4
`define CTA_LFSR_BIT      0
`define CTA_VIC_IDX_LSB   7
`define CTA_TSTATE_BIT    0

// Reset values and LFSR taps
`define CTA_TDATA_RST     32'h00000000
`define CTA_TSTATE_RST    1'b0
`define CTA_LFSR_SEED     8'h01
`define CTA_LFSR_TAPS     8'hB8

`endif

// ### cta_core_model.sv
/*
  Behavioural model of the processor core issuing coprocessor transfers
  to the cache test access block.
  Assumes the block answers with a combinational ready and a registered answer.
*/
`timescale 1ns/1ps
module cta_core_model (
  input  wire logic        clk_sys_i,  // System clock
  input  wire logic        cp_ready_i, // Block can take a transfer
  input  wire logic [31:0] cp_rdata_i, // Read answer
  output logic             cp_valid_o, // Transfer presented
  output logic             cp_write_o, // 1 write, 0 read
  output logic [2:0]       cp_opc1_o,  // opcode_1
  output logic [3:0]       cp_crn_o,   // Primary register
  output logic [3:0]       cp_crm_o,   // CRm
  output logic [2:0]       cp_opc2_o,  // opcode_2
  output logic [31:0]      cp_wdata_o  // Source value
);
  // Idle bus at time zero
  initial begin
    cp_valid_o = 1'b0;
    cp_write_o = 1'b0;
    cp_opc1_o  = 3'h0;
    cp_crn_o   = 4'h0;
    cp_crm_o   = 4'h0;
    cp_opc2_o  = 3'h0;
    cp_wdata_o = 32'h0;
  end

  // One transfer: present after an edge, hold until taken, then scramble
  // the fields except opcode_1 so a stale value never looks like a live one
  task automatic op(input logic wr, input logic [2:0] o1, input logic [3:0] rn,
                    input logic [3:0] rm, input logic [2:0] o2,
                    input logic [31:0] wd, output logic [31:0] rd);
    logic taken;
    @(posedge clk_sys_i);
    #1;
    cp_valid_o = 1'b1;
    cp_write_o = wr;
    cp_opc1_o  = o1;
    cp_crn_o   = rn;
    cp_crm_o   = rm;
    cp_opc2_o  = o2;
    cp_wdata_o = wd;
    taken = 1'b0;
    // Ready is sampled mid-cycle; it is stable up to the next edge
    while (!taken) begin
      @(negedge clk_sys_i);
      taken = (cp_ready_i === 1'b1);
      @(posedge clk_sys_i);
    end
    #1;
    cp_valid_o = 1'b0;
    cp_write_o = ~wr;
    cp_crn_o   = ~rn;
    cp_crm_o   = ~rm;
    cp_opc2_o  = ~o2;
    cp_wdata_o = ~wd;
    // Answer is registered at the accepting edge and then holds; read it one edge later
    @(posedge clk_sys_i);
    #1;
    rd = cp_rdata_i;
  endtask
endmodule

// ### cta_dec_if.sv
/*
  Carrier between the top module and its operation decoder.
  Assumes cta_pkg is compiled first.
*/
`timescale 1ns/1ps
interface cta_dec_if;
  import cta_pkg::*;

  logic         write;  // High for a coprocessor write
  logic [2:0]   opc1;   // opcode_1 field
  logic [3:0]   crn;    // Primary register number
  logic [3:0]   crm;    // CRm field
  logic [2:0]   opc2;   // opcode_2 field
  cta_op_e      op;     // Decoded operation

  modport dec  (input write, opc1, crn, crm, opc2, output op);
  modport core (output write, opc1, crn, crm, opc2, input op);
endinterface

// ### cta_decode.sv
/*
  Combinational decoder of coprocessor transfer fields into block operations.
  Assumes the fields come straight from the core on the system clock.
*/
`timescale 1ns/1ps
`include "cta_consts.svh"
module cta_decode
  import cta_pkg::*;
(
  cta_dec_if.dec dif
);

  // Map one transfer encoding onto an operation; unknown ones do nothing
  function automatic cta_op_e cta_decode_op(input logic       wr,
                                            input logic [2:0] o1,
                                            input logic [3:0] rn,
                                            input logic [3:0] rm,
                                            input logic [2:0] o2);
    cta_op_e res;
    res = cta_op_none;
    if (wr && o1 == `CTA_OPC1_MAINT && rn == `CTA_CRN_INV && rm == `CTA_CRM_INV
        && o2 == `CTA_OPC2_INV) begin
      res = cta_op_inv;
    end else if (wr && o1 == `CTA_OPC1_MAINT && rn == `CTA_CRN_VIC && o2[2:1] == 2'h0) begin
      // Either opcode_2 encoding selects the same write
      if (rm == `CTA_CRM_VIC_BASE) begin
        res = cta_op_vic_base;
      end else if (rm == `CTA_CRM_VIC) begin
        res = cta_op_vic;
      end
    end else if (rn == `CTA_CRN_TEST) begin
      if (wr && o1 == `CTA_OPC1_CACHE && rm == `CTA_CRM_TAG) begin
        case (o2)
          `CTA_OPC2_TAG_RD: res = cta_op_tag_rd;
          `CTA_OPC2_TAG_WR: res = cta_op_tag_wr;
          `CTA_OPC2_MATCH:  res = cta_op_match;
          default:          res = cta_op_none;
        endcase
      end else if (wr && o1 == `CTA_OPC1_CACHE && rm == `CTA_CRM_DATA) begin
        case (o2)
          `CTA_OPC2_DAT_RD: res = cta_op_dat_rd;
          `CTA_OPC2_DAT_WR: res = cta_op_dat_wr;
          default:          res = cta_op_none;
        endcase
      end else if (o1 == `CTA_OPC1_TDATA && rm == `CTA_CRM_TDATA) begin
        if (o2 == `CTA_OPC2_TDATA) begin
          res = wr ? cta_op_td_wr : cta_op_td_rd;
        end else if (o2 == `CTA_OPC2_VCAP && !wr) begin
          res = cta_op_vcap_rd;
        end
      end else if (o1 == `CTA_OPC1_TSTATE && rm == `CTA_CRM_TSTATE
                   && o2 == `CTA_OPC2_TSTATE) begin
        res = wr ? cta_op_ts_wr : cta_op_ts_rd;
      end
    end
    return res;
  endfunction

  // Pure decode, no state
  always_comb begin
    dif.op = cta_decode_op(dif.write, dif.opc1, dif.crn, dif.crm, dif.opc2);
  end

endmodule

// ### cta_lfsr.sv
/*
  Free-running Galois LFSR that models the replacement state bit.
  Assumes one system clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "cta_consts.svh"
module cta_lfsr #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys_i, // System clock
  input  wire logic         reset_i,   // Asynchronous reset
  output logic              bit_o      // Current low state bit
);

  logic [W-1:0] state_r;   // Shift register
  logic [W-1:0] state_nxt; // Next value

  // Shift right, fold taps in when a one drops out
  always_comb begin
    state_nxt = {1'b0, state_r[W-1:1]};
    if (state_r[0]) begin
      state_nxt = state_nxt ^ W'(`CTA_LFSR_TAPS);
    end
  end

  // Seed is never zero, so the sequence cannot lock up
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= W'(`CTA_LFSR_SEED);
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bit_o = state_r[0];

endmodule

// ### cta_pkg.sv
/*
  Types shared by the cache test access block: decoded operations and states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cta_pkg;

  // Decoded coprocessor operation
  typedef enum logic [3:0] {
    cta_op_none,
    cta_op_inv,
    cta_op_vic_base,
    cta_op_vic,
    cta_op_tag_rd,
    cta_op_tag_wr,
    cta_op_dat_rd,
    cta_op_dat_wr,
    cta_op_match,
    cta_op_td_wr,
    cta_op_td_rd,
    cta_op_vcap_rd,
    cta_op_ts_wr,
    cta_op_ts_rd
  } cta_op_e;

  // Sequencer state
  typedef enum logic {
    cta_idle,
    cta_exec
  } cta_state_e;

endpackage

// ### cta_top.sv
/*
  Cache test access port: tag store, data store, victim pointers and the
  test data register, driven by coprocessor transfers from the core.
  Assumes the core holds a request until ready is seen and shares clk_sys_i.
*/
`timescale 1ns/1ps
`include "cta_consts.svh"
module cta_top
  import cta_pkg::*;
#(
  parameter int unsigned IDX_W  = 6, // Index bits, 64 entries per segment
  parameter int unsigned WORD_W = 3  // Word bits, 8 words per line
) (
  input  wire logic        clk_sys_i,     // System clock
  input  wire logic        reset_i,       // Asynchronous reset
  input  wire logic        cp_valid_i,    // Core presents a transfer
  input  wire logic        cp_write_i,    // High for write, low for read
  input  wire logic [2:0]  cp_opc1_i,     // opcode_1
  input  wire logic [3:0]  cp_crn_i,      // Primary register
  input  wire logic [3:0]  cp_crm_i,      // CRm
  input  wire logic [2:0]  cp_opc2_i,     // opcode_2
  input  wire logic [31:0] cp_wdata_i,    // Source value
  output logic             cp_ready_o,    // Block idle, can take a transfer
  output logic [31:0]      cp_rdata_o,    // Read answer
  output logic             test_enable_o  // Test state bit
);

  localparam int unsigned SEG_W = 2;                 // Segment field 6:5
  localparam int unsigned TAG_W = 32 - `CTA_TAG_LSB; // Stored tag width
  localparam int unsigned SEGS  = 1 << SEG_W;
  localparam int unsigned ENT   = SEGS << IDX_W;
  localparam int unsigned WORDS = ENT << WORD_W;

  cta_dec_if dif();                 // Decoder carrier
  logic      lfsr_bit;              // Replacement state bit

  cta_state_e        state_r, state_nxt;   // Sequencer
  cta_op_e           op_r, op_nxt;         // Operation in flight
  logic [31:0]       wd_r, wd_nxt;         // Its source value
  logic [31:0]       tdata_r, tdata_nxt;   // Cache test data register
  logic [31:0]       rdata_r, rdata_nxt;   // Read answer register
  logic              ts_r, ts_nxt;         // Test state enable
  logic [IDX_W-1:0]  vcap_r, vcap_nxt;     // Victim captured at tag read
  logic [IDX_W-1:0]  vic_r [SEGS];         // Victim pointer per segment
  logic [IDX_W-1:0]  vic_nxt [SEGS];
  logic [SEGS-1:0]   mode_r, mode_nxt;     // High: pointer set with base
  logic [TAG_W-1:0]  tag_r [ENT];          // Tag store
  logic [TAG_W-1:0]  tag_nxt [ENT];
  logic [ENT-1:0]    valid_r, valid_nxt;   // Valid bits
  logic [31:0]       data_r [WORDS];       // Data store
  logic [31:0]       data_nxt [WORDS];

  logic              accept;               // Transfer taken
  logic [SEG_W-1:0]  seg;                  // Addressed segment
  logic [WORD_W-1:0] word;                 // Addressed word
  logic [IDX_W-1:0]  idx;                  // That segment's victim
  logic [SEG_W+IDX_W-1:0] ent;             // Flat entry number

  // Decoder and replacement bit source
  assign dif.write = cp_write_i;
  assign dif.opc1  = cp_opc1_i;
  assign dif.crn   = cp_crn_i;
  assign dif.crm   = cp_crm_i;
  assign dif.opc2  = cp_opc2_i;

  cta_decode u_decode (
    .dif (dif)
  );

  cta_lfsr #(
    .W (8)
  ) u_lfsr (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .bit_o     (lfsr_bit)
  );

  // One flat index for an entry and a word within its line
  function automatic logic [SEG_W+IDX_W+WORD_W-1:0] word_addr(
      input logic [SEG_W+IDX_W-1:0] e, input logic [WORD_W-1:0] w);
    return {e, w};
  endfunction

  // Core stalls while an operation executes
  assign accept     = cp_valid_i && (state_r == cta_idle);
  assign cp_ready_o = (state_r == cta_idle);

  // Address fields come from the source value
  assign seg  = wd_r[`CTA_SEG_LSB +: SEG_W];
  assign word = wd_r[`CTA_WORD_LSB +: WORD_W];
  assign idx  = vic_r[seg];
  assign ent  = {seg, idx};

  // Sequencer and the read answer: reads answer from current state at accept
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    wd_nxt    = wd_r;
    rdata_nxt = rdata_r;
    case (state_r)
      cta_idle: begin
        if (accept) begin
          state_nxt = cta_exec;
          op_nxt    = dif.op;
          wd_nxt    = cp_wdata_i;
          case (dif.op)
            cta_op_td_rd:   rdata_nxt = tdata_r;
            cta_op_vcap_rd: rdata_nxt = 32'(vcap_r);
            cta_op_ts_rd:   rdata_nxt = 32'(ts_r);
            default:        rdata_nxt = rdata_r;
          endcase
        end
      end
      cta_exec: begin
        state_nxt = cta_idle;
      end
      default: begin
        state_nxt = cta_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= cta_idle;
      op_r    <= cta_op_none;
      wd_r    <= 32'h00000000;
      rdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      wd_r    <= wd_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Execution of the operation in flight; stores change only here
  always_comb begin
    logic             hit;
    logic [IDX_W-1:0] hit_idx;
    logic             adv;
    logic [TAG_W-1:0] cmp;
    hit       = 1'b0;
    hit_idx   = '0;
    adv       = 1'b0;
    cmp       = wd_r[31:`CTA_TAG_LSB];
    tdata_nxt = tdata_r;
    ts_nxt    = ts_r;
    vcap_nxt  = vcap_r;
    vic_nxt   = vic_r;
    mode_nxt  = mode_r;
    tag_nxt   = tag_r;
    valid_nxt = valid_r;
    data_nxt  = data_r;
    if (state_r == cta_exec) begin
      case (op_r)
        cta_op_inv: begin
          valid_nxt = '0;
        end
        cta_op_vic_base, cta_op_vic: begin
          // Segment at bit 5, index from its own field
          vic_nxt[seg]  = wd_r[`CTA_VIC_IDX_LSB +: IDX_W];
          mode_nxt[seg] = (op_r == cta_op_vic_base);
        end
        cta_op_td_wr: begin
          tdata_nxt = wd_r;
        end
        cta_op_ts_wr: begin
          ts_nxt = wd_r[`CTA_TSTATE_BIT];
        end
        cta_op_tag_rd: begin
          if (ts_r) begin
            // Bits 6:5 and dirty bits read zero, bit 0 LFSR
            tdata_nxt = {tag_r[ent], 2'b00, valid_r[ent], 3'b000, lfsr_bit};
            vcap_nxt  = idx;
            adv       = 1'b1;
          end
        end
        cta_op_tag_wr: begin
          if (ts_r) begin
            tag_nxt[ent]   = cmp;
            valid_nxt[ent] = wd_r[`CTA_VALID_BIT];
            adv            = 1'b1;
          end
        end
        cta_op_dat_rd: begin
          if (ts_r) begin
            tdata_nxt = data_r[word_addr(ent, word)];
            adv       = mode_r[seg];
          end
        end
        cta_op_dat_wr: begin
          if (ts_r) begin
            data_nxt[word_addr(ent, word)] = tdata_r;
            adv                            = mode_r[seg];
          end
        end
        cta_op_match: begin
          if (ts_r) begin
            // Local search only; a miss loads zero, no fill
            for (int i = 0; i < (1 << IDX_W); i++) begin
              if (!hit && valid_r[{seg, IDX_W'(i)}] && tag_r[{seg, IDX_W'(i)}] == cmp) begin
                hit     = 1'b1;
                hit_idx = IDX_W'(i);
              end
            end
            tdata_nxt = hit ? data_r[word_addr({seg, hit_idx}, word)] : 32'h00000000;
          end
        end
        default: begin
          tdata_nxt = tdata_r;
        end
      endcase
      // Pointer wraps to zero after the last entry
      if (adv) begin
        vic_nxt[seg] = idx + IDX_W'(1);
      end
    end
  end

  // Store registers; the large arrays reset too so reads are never undefined
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tdata_r <= `CTA_TDATA_RST;
      ts_r    <= `CTA_TSTATE_RST;
      vcap_r  <= '0;
      mode_r  <= '0;
      valid_r <= '0;
      for (int s = 0; s < SEGS; s++) begin
        vic_r[s] <= '0;
      end
      for (int e = 0; e < ENT; e++) begin
        tag_r[e] <= '0;
      end
      for (int w = 0; w < WORDS; w++) begin
        data_r[w] <= 32'h00000000;
      end
    end else begin
      tdata_r <= tdata_nxt;
      ts_r    <= ts_nxt;
      vcap_r  <= vcap_nxt;
      mode_r  <= mode_nxt;
      valid_r <= valid_nxt;
      vic_r   <= vic_nxt;
      tag_r   <= tag_nxt;
      data_r  <= data_nxt;
    end
  end

  assign cp_rdata_o    = rdata_r;
  assign test_enable_o = ts_r;

  // Checks on the sequencer and the stores
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic exec;        // Operation executing
  logic tag_op;      // Tag read or write executing with test on
  logic dat_op;      // Data read or write executing with test on
  assign exec   = (state_r == cta_exec);
  assign tag_op = exec && ts_r && (op_r == cta_op_tag_rd || op_r == cta_op_tag_wr);
  assign dat_op = exec && ts_r && (op_r == cta_op_dat_rd || op_r == cta_op_dat_wr);

  sequence s_td_load;
    accept && dif.op == cta_op_td_wr;
  endsequence

  sequence s_td_back;
    !cp_ready_o ##1 cp_ready_o;
  endsequence

  a_stall_one_cycle: assert property (accept |=> s_td_back)
    else $error("Operation did not stall exactly one cycle");
  a_td_write_load: assert property (s_td_load |=> ##1 tdata_r == $past(cp_wdata_i, 2))
    else $error("Test data register not loaded by write");
  a_td_read_back: assert property (accept && dif.op == cta_op_td_rd |=>
                                   cp_rdata_o == $past(tdata_r))
    else $error("Test data read returned wrong value");
  a_inv_clears: assert property (exec && op_r == cta_op_inv |=> valid_r == '0)
    else $error("Invalidate left valid entries");
  a_tag_rd_fmt: assert property (exec && ts_r && op_r == cta_op_tag_rd |=>
                                 tdata_r[6:5] == 2'b00 && tdata_r[3:1] == 3'b000)
    else $error("Tag read bits not zero");
  a_tag_advance: assert property (tag_op |=>
                                  vic_r[$past(seg)] == $past(idx) + IDX_W'(1))
    else $error("Victim pointer did not advance after tag op");
  a_dat_hold: assert property (dat_op && !mode_r[seg] |=>
                               vic_r[$past(seg)] == $past(idx))
    else $error("Victim-only pointer moved on data op");
  a_dat_advance: assert property (dat_op && mode_r[seg] |=>
                                  vic_r[$past(seg)] == $past(idx) + IDX_W'(1))
    else $error("Base-mode pointer did not advance on data op");
  a_test_gate: assert property (exec && !ts_r && op_r != cta_op_inv |=>
                                $stable(valid_r))
    else $error("Store changed with test state off");
  a_vcap_tag_rd: assert property (exec && ts_r && op_r == cta_op_tag_rd |=>
                                  vcap_r == $past(idx))
    else $error("Victim not captured on tag read");

endmodule

// ### cta_top_tb_top.sv
/*
  Self-checking testbench for the cache test access block.
  Assumes the core model drives every transfer and the design body holds
  its own assertions.
*/
`timescale 1ns/1ps
module cta_top_tb_top;
  import cta_pkg::*;

  logic        clk_sys_i;  // System clock, 25 ns
  logic        reset_i;    // Active high reset
  logic        cp_valid;   // Core transfer strobe
  logic        cp_write;   // Core direction
  logic [2:0]  cp_opc1;    // opcode_1
  logic [3:0]  cp_crn;     // Primary register
  logic [3:0]  cp_crm;     // CRm
  logic [2:0]  cp_opc2;    // opcode_2
  logic [31:0] cp_wdata;   // Source value
  logic        cp_ready;   // Block ready
  logic [31:0] cp_rdata;   // Block answer
  logic        test_en;    // Test state bit
  logic [31:0] rdv;        // Last answer seen by the core
  logic [24:0] tg [0:4];   // Tag patterns
  int          n_mismatch; // Mismatch count
  int          checked;    // Comparison count

  // Four entries per segment so wrap is reached in a few writes
  cta_top #(.IDX_W(2), .WORD_W(3)) cta_top_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cp_valid_i(cp_valid),
    .cp_write_i(cp_write), .cp_opc1_i(cp_opc1), .cp_crn_i(cp_crn),
    .cp_crm_i(cp_crm), .cp_opc2_i(cp_opc2), .cp_wdata_i(cp_wdata),
    .cp_ready_o(cp_ready), .cp_rdata_o(cp_rdata), .test_enable_o(test_en));

  cta_core_model cta_core_model_i (
    .clk_sys_i(clk_sys_i), .cp_ready_i(cp_ready), .cp_rdata_i(cp_rdata),
    .cp_valid_o(cp_valid), .cp_write_o(cp_write), .cp_opc1_o(cp_opc1),
    .cp_crn_o(cp_crn), .cp_crm_o(cp_crm), .cp_opc2_o(cp_opc2),
    .cp_wdata_o(cp_wdata));

  // Clock generator
  always #12.5 clk_sys_i = ~clk_sys_i;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Shorthands over the core model
  task automatic xfer(input logic wr, input logic [2:0] o1, input logic [3:0] rn,
                      input logic [3:0] rm, input logic [2:0] o2, input logic [31:0] wd);
    cta_core_model_i.op(wr, o1, rn, rm, o2, wd, rdv);
  endtask

  task automatic td_wr(input logic [31:0] d);
    xfer(1'b1, 3'h3, 4'hF, 4'h3, 3'h0, d);
  endtask

  task automatic td_rd(input logic [31:0] exp);
    xfer(1'b0, 3'h3, 4'hF, 4'h3, 3'h0, 32'h0);
    chk(rdv, exp);
  endtask

  // Bit 0 carries the free-running replacement bit, so it is masked
  task automatic td_rd_m(input logic [31:0] exp);
    xfer(1'b0, 3'h3, 4'hF, 4'h3, 3'h0, 32'h0);
    chk({rdv[31:1], 1'b0}, exp);
  endtask

  // Victim pointer write: index from bit 7 up, segment at 6:5
  task automatic vic(input logic [3:0] rm, input logic [2:0] o2,
                     input logic [1:0] seg, input logic [1:0] idx);
    xfer(1'b1, 3'h0, 4'h9, rm, o2, {23'h0, idx, seg, 5'h00});
  endtask

  task automatic cache(input logic [3:0] rm, input logic [2:0] o2, input logic [31:0] a);
    xfer(1'b1, 3'h2, 4'hF, rm, o2, a);
  endtask

  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    clk_sys_i  = 1'b0;
    reset_i    = 1'b1;
    n_mismatch = 0;
    checked    = 0;
    for (int i = 0; i < 5; i++) begin
      tg[i] = 25'h0ABC000 + 25'(i) * 25'h0000111;
    end
    repeat (6) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    chk({31'h0, test_en}, 32'h0);
    chk({31'h0, cp_ready}, 32'h1);
    // Test data register round trips
    td_wr(32'hA5A53C3C);
    td_rd(32'hA5A53C3C);
    td_wr(32'hFFFFFFFF);
    td_rd(32'hFFFFFFFF);
    // Tag write while test state is off must leave the store alone
    vic(4'h1, 3'h0, 2'h2, 2'h0);
    cache(4'h7, 3'h6, {tg[0], 2'h2, 1'b1, 4'h0});
    xfer(1'b1, 3'h7, 4'hF, 4'hF, 3'h7, 32'h1);
    chk({31'h0, test_en}, 32'h1);
    xfer(1'b0, 3'h7, 4'hF, 4'hF, 3'h7, 32'h0);
    chk(rdv, 32'h1);
    // A read with a tag-read encoding is no operation: answer and register hold
    xfer(1'b0, 3'h2, 4'hF, 4'h7, 3'h2, 32'h40);
    chk(rdv, 32'h1);
    td_rd(32'hFFFFFFFF);
    vic(4'h1, 3'h0, 2'h2, 2'h0);
    cache(4'h7, 3'h2, 32'h40);
    td_rd_m(32'h0);
    // Five tag writes in four entries: the fifth wraps onto entry 0
    vic(4'h1, 3'h1, 2'h2, 2'h0);
    for (int i = 0; i < 5; i++) begin
      cache(4'h7, 3'h6, {tg[i], 2'h2, 1'b1, 3'h7, 1'b0});
    end
    vic(4'h1, 3'h0, 2'h2, 2'h0);
    for (int i = 0; i < 4; i++) begin
      cache(4'h7, 3'h2, 32'h40);
      td_rd_m({(i == 0) ? tg[4] : tg[i], 2'h0, 1'b1, 4'h0});
      xfer(1'b0, 3'h3, 4'hF, 4'h3, 3'h1, 32'h0);
      chk(rdv, 32'(i));
    end
    // Victim-only mode: a whole line stays on one index
    vic(4'h1, 3'h0, 2'h1, 2'h0);
    for (int w = 0; w < 8; w++) begin
      td_wr(32'h5A5A5A00 + 32'(w));
      cache(4'hB, 3'h6, 32'h20 + 32'(w) * 4);
    end
    for (int w = 0; w < 8; w++) begin
      td_wr(32'h0);
      cache(4'hB, 3'h2, 32'h20 + 32'(w) * 4);
      td_rd(32'h5A5A5A00 + 32'(w));
    end
    // Base mode: each data write moves to the next index
    vic(4'h0, 3'h0, 2'h1, 2'h2);
    td_wr(32'h11112222);
    cache(4'hB, 3'h6, 32'h2C);
    td_wr(32'h33334444);
    cache(4'hB, 3'h6, 32'h2C);
    vic(4'h1, 3'h0, 2'h1, 2'h2);
    cache(4'hB, 3'h2, 32'h2C);
    td_rd(32'h11112222);
    cache(4'h7, 3'h2, 32'h20);
    cache(4'hB, 3'h2, 32'h2C);
    td_rd(32'h33334444);
    // Match: hit returns the word, miss returns zero with no fill
    vic(4'h1, 3'h0, 2'h2, 2'h1);
    td_wr(32'hC0DE0055);
    cache(4'hB, 3'h6, 32'h54);
    cache(4'h7, 3'h5, {tg[1], 2'h2, 3'h5, 2'h0});
    td_rd(32'hC0DE0055);
    td_wr(32'hFFFFFFFF);
    cache(4'h7, 3'h5, {25'h1FFFFFF, 2'h2, 3'h5, 2'h0});
    td_rd(32'h0);
    // Invalidate ignores its source value and kills every hit
    xfer(1'b1, 3'h0, 4'h7, 4'h7, 3'h0, 32'hDEADBEEF);
    td_wr(32'hFFFFFFFF);
    cache(4'h7, 3'h5, {tg[1], 2'h2, 3'h5, 2'h0});
    td_rd(32'h0);
    close_out();
  end
endmodule
